// >>> inc/csr_consts.svh
// Constants for the chip settings readout block: report codes, byte
// positions, register offsets, field positions and reset values.
// Assumes it is included by its bare name from every design file.
`ifndef CSR_CONSTS_SVH
`define CSR_CONSTS_SVH

// -----------------------------------------------------------------
// Report codes
// -----------------------------------------------------------------
`define CSR_CMD_READ_FLASH 8'hb0
`define CSR_SUB_CHIP_SETTINGS 8'h00
`define CSR_STATUS_OK 8'h00
`define CSR_STATUS_UNSUPPORTED 8'h01
`define CSR_STRUCT_LEN 8'h0e
`define CSR_REPORT_LAST 6'h3f

// -----------------------------------------------------------------
// Byte positions inside the response report
// -----------------------------------------------------------------
`define CSR_BYTE_CMD 6'h00
`define CSR_BYTE_STATUS 6'h01
`define CSR_BYTE_LEN 6'h02
`define CSR_BYTE_CHIP 6'h04
`define CSR_BYTE_CLK 6'h05
`define CSR_BYTE_DAC 6'h06

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define CSR_OFS_CHIP_CFG 3'h0
`define CSR_OFS_CLK_CFG 3'h1
`define CSR_OFS_DAC_CFG 3'h2
`define CSR_OFS_PIN_CTRL 3'h3
`define CSR_OFS_STATUS 3'h4

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define CSR_CHIP_SERIAL_EN 7
`define CSR_CHIP_RX_IDLE 6
`define CSR_CHIP_TX_IDLE 5
`define CSR_CHIP_I2C_IDLE 4
`define CSR_CHIP_SUSP_IDLE 3
`define CSR_CHIP_CFG_IDLE 2
`define CSR_CHIP_SEC_HI 1
`define CSR_CHIP_SEC_LO 0
`define CSR_CLK_DIV_HI 4
`define CSR_DAC_REF_HI 7
`define CSR_DAC_REF_LO 6
`define CSR_DAC_REF_SRC 5
`define CSR_DAC_VAL_HI 4
`define CSR_PIN_I2C_EN 0
`define CSR_PIN_SUSP_EN 1
`define CSR_PIN_CFG_EN 2
`define CSR_PIN_CLK_EN 3

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define CSR_RST_CHIP_CFG 8'h00
`define CSR_RST_CLK_CFG 8'h00
`define CSR_RST_DAC_CFG 8'h00
`define CSR_RST_PIN_CTRL 8'h00

`endif

// >>> inc/csr_pkg.sv
// Types for the chip settings readout block.
// Assumes csr_consts.svh supplies the numbers; this file holds types only.
package csr_pkg;

   // Response engine states
   typedef enum logic [0:0] {
      CSR_IDLE,
      CSR_SEND
   } csr_state_t;

   // Decoded configuration security level
   typedef enum logic [1:0] {
      CSR_SEC_UNSECURED,
      CSR_SEC_PASSWORD,
      CSR_SEC_LOCKED
   } csr_sec_t;

   // Whole state of the readout top
   typedef struct packed {
      csr_state_t state;
      logic [5:0] index;
      logic [7:0] status;
      logic [7:0] snap_chip;
      logic [7:0] snap_clk;
      logic [7:0] snap_dac;
      logic resp_valid;
      logic [7:0] resp_byte;
      logic [7:0] chip_cfg;
      logic [7:0] clk_cfg;
      logic [7:0] dac_cfg;
      logic [7:0] pin_ctrl;
      logic [7:0] rdata;
      logic rx_ind;
      logic tx_ind;
      logic i2c_ind;
      logic susp_ind;
      logic cfg_ind;
   } csr_top_t;

   // Whole state of the clock output divider
   typedef struct packed {
      logic [4:0] count;
      logic out;
   } csr_div_t;

endpackage

// >>> sim/csr_host_model.sv
// Host model: sends command reports and takes response bytes.
// Assumes the bench seeds the random source and calls send after an edge.
module csr_host_model (
   // Clock
   input wire logic sys_clk,
   // Command report
   output logic cmd_valid,
   input wire logic cmd_ready,
   output logic [7:0] cmd_code,
   output logic [7:0] cmd_sub,
   // Response report
   input wire logic resp_valid,
   output logic resp_ready,
   input wire logic [7:0] resp_byte,
   input wire logic [5:0] resp_index,
   input wire logic resp_last
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got [64]; // Bytes taken, by index
   logic slow = 1'b0; // Stall the sink at random
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_sub = 8'h00;
      resp_ready = 1'b0;
   end
   // Sink readiness: prompt or stalling
   always @(posedge sys_clk) resp_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
   // Keep every accepted byte
   always @(negedge sys_clk) if (resp_valid && resp_ready) got[resp_index] <= resp_byte;
   // Hold the command until taken, then, if want is set, wait for the last byte
   task automatic send(input logic [7:0] code, input logic [7:0] sub, input logic want);
      cmd_valid <= 1'b1;
      cmd_code <= code;
      cmd_sub <= sub;
      do @(posedge sys_clk); while (!cmd_ready);
      cmd_valid <= 1'b0;
      cmd_code <= ~code; // Released lines do not keep the last value
      cmd_sub <= ~sub;
      if (want) do @(posedge sys_clk); while (!(resp_valid && resp_ready && resp_last));
   endtask
endmodule // csr_host_model

// >>> sim/csr_readout_chk.sv
// Checker for the chip settings readout: report framing and pin levels.
// Assumes it is bound to csr_readout and sees only that module's ports.
`include "csr_consts.svh"

module csr_readout_chk (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Register writes
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   // Command and response
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [7:0] cmd_code,
   input wire logic resp_valid,
   input wire logic resp_ready,
   input wire logic [7:0] resp_byte,
   input wire logic [5:0] resp_index,
   input wire logic resp_last,
   // Activity inputs
   input wire logic uart_rx_busy,
   input wire logic uart_tx_busy,
   input wire logic i2c_busy,
   input wire logic usb_suspended,
   input wire logic usb_configured,
   // Pins governed by the settings
   input wire logic rx_activity_indicator,
   input wire logic tx_activity_indicator,
   input wire logic i2c_traffic_indicator,
   input wire logic suspend_indicator,
   input wire logic usb_configured_indicator,
   input wire logic serial_number_enable,
   input wire logic [1:0] security_level,
   input wire logic [1:0] dac_ref_level,
   input wire logic internal_voltage_reference,
   input wire logic [4:0] dac_value
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Shadow settings
   // ----------------------------------------------------------------
   logic [7:0] chip_reg; // Chip settings byte
   logic [7:0] dac_reg; // DAC setup byte
   logic [3:0] pin_reg; // Pin enables
   // Follows writes exactly as the block's own registers should
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         chip_reg <= 8'h00;
         dac_reg <= 8'h00;
         pin_reg <= 4'h0;
      end else if (reg_wr && reg_addr == `CSR_OFS_CHIP_CFG) begin
         chip_reg <= reg_wdata;
      end else if (reg_wr && reg_addr == `CSR_OFS_DAC_CFG) begin
         dac_reg <= reg_wdata;
      end else if (reg_wr && reg_addr == `CSR_OFS_PIN_CTRL) begin
         pin_reg <= reg_wdata[3:0];
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // A flash-read command taken at an edge
   sequence take_read;
      cmd_valid && cmd_ready && cmd_code == `CSR_CMD_READ_FLASH;
   endsequence
   // Opening byte of the report, engine busy
   sequence echo_first;
      resp_valid && !cmd_ready && resp_index == 6'h00 && resp_byte == `CSR_CMD_READ_FLASH;
   endsequence
   echo_code_a:
   assert property (take_read |=> echo_first) else $error("report did not open with the echo");
   byte_hold_a:
   assert property (resp_valid && !resp_ready |=> resp_valid && $stable(resp_byte) && $stable(resp_index))
      else $error("stalled byte changed");
   index_step_a:
   assert property (resp_valid && resp_ready && !resp_last |=> resp_valid && resp_index == $past(resp_index) + 6'h01)
      else $error("index did not advance by one");
   report_end_a:
   assert property (resp_valid && resp_ready && resp_last |=> !resp_valid && cmd_ready) else $error("no report end");
   last_flag_a:
   assert property (resp_last == (resp_valid && resp_index == `CSR_REPORT_LAST)) else $error("last flag wrong");
   busy_refuse_a:
   assert property (resp_valid |-> !cmd_ready) else $error("command accepted while sending");
   serial_enable_a:
   assert property (serial_number_enable == chip_reg[7]) else $error("serial enable wrong");
   security_map_a:
   assert property (security_level == (chip_reg[1] ? 2'h2 : chip_reg[1:0])) else $error("security level wrong");
   dac_setup_a:
   assert property ({dac_ref_level, internal_voltage_reference, dac_value} == dac_reg) else $error("dac setup wrong");
   uart_leds_a:
   assert property ($past(rst_b) |-> rx_activity_indicator == $past(chip_reg[6] ^ uart_rx_busy)
      && tx_activity_indicator == $past(chip_reg[5] ^ uart_tx_busy)) else $error("uart indicator wrong");
   enabled_pins_a:
   assert property ($past(rst_b) |-> i2c_traffic_indicator == $past(chip_reg[4] ^ (pin_reg[0] & i2c_busy))
      && suspend_indicator == $past(chip_reg[3] ^ (pin_reg[1] & usb_suspended))
      && usb_configured_indicator == $past(chip_reg[2] ^ (pin_reg[2] & usb_configured)))
      else $error("enabled indicator wrong");
endmodule // csr_readout_chk

bind csr_readout csr_readout_chk u_chk (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .cmd_valid, .cmd_ready,
   .cmd_code, .resp_valid, .resp_ready, .resp_byte, .resp_index, .resp_last, .uart_rx_busy, .uart_tx_busy,
   .i2c_busy, .usb_suspended, .usb_configured, .rx_activity_indicator, .tx_activity_indicator,
   .i2c_traffic_indicator, .suspend_indicator, .usb_configured_indicator, .serial_number_enable,
   .security_level, .dac_ref_level, .internal_voltage_reference, .dac_value);

// >>> sim/tb_chip_settings_readout.sv
// Testbench for the chip settings readout: random settings, report checks.
// Assumes the checker binds itself and the host model is compiled.
`include "csr_consts.svh"

module tb_chip_settings_readout;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic sys_clk = 1'b0, rst_b = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, resp_byte, cmd_code, cmd_sub, c, k, d;
   logic reg_wr = 1'b0, reg_rd = 1'b0, cmd_valid, cmd_ready, resp_valid, resp_ready, resp_last;
   logic uart_rx_busy = 1'b0, uart_tx_busy = 1'b0, i2c_busy = 1'b0, usb_suspended = 1'b0, usb_configured = 1'b0;
   logic rx_activity_indicator, tx_activity_indicator, i2c_traffic_indicator, suspend_indicator;
   logic usb_configured_indicator, serial_number_enable, clock_output, internal_voltage_reference;
   logic [5:0] resp_index;
   logic [1:0] security_level, dac_ref_level;
   logic [4:0] dac_value;
   int miscompares = 0, cmp_count = 0, cycles = 0;
   // Design and host
   csr_readout dut (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd_valid,
      .cmd_ready, .cmd_code, .cmd_sub, .resp_valid, .resp_ready, .resp_byte, .resp_index, .resp_last,
      .uart_rx_busy, .uart_tx_busy, .i2c_busy, .usb_suspended, .usb_configured, .rx_activity_indicator,
      .tx_activity_indicator, .i2c_traffic_indicator, .suspend_indicator, .usb_configured_indicator,
      .serial_number_enable, .security_level, .clock_output, .dac_ref_level, .internal_voltage_reference,
      .dac_value);
   csr_host_model host (.sys_clk, .cmd_valid, .cmd_ready, .cmd_code, .cmd_sub, .resp_valid, .resp_ready,
      .resp_byte, .resp_index, .resp_last);
   // ----------------------------------------------------------------
   // Clock, activity and watchdog
   // ----------------------------------------------------------------
   always #12.5 sys_clk = ~sys_clk;
   // Random activity on every busy and state input
   always @(posedge sys_clk) {uart_rx_busy, uart_tx_busy, i2c_busy, usb_suspended, usb_configured} <= 5'($urandom);
   // Cut a hang short
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin miscompares++; close_out(); end
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic close_out();
      if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin miscompares++; $display("Error %s expected %h seen %h", what, exp, got); end
   endtask
   // One write cycle, then an idle cycle
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
      @(posedge sys_clk); reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   // One read cycle; data are taken at the following edge
   task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge sys_clk); reg_rd <= 1'b0;
      @(posedge sys_clk); chk("reg_rdata", exp & m, reg_rdata & m);
   endtask
   // Expected report byte for a sub-code and settings
   function automatic logic [7:0] exp_byte(input int i, input logic [7:0] sub, c, k, d);
      if (i == 0) return `CSR_CMD_READ_FLASH;
      if (sub != `CSR_SUB_CHIP_SETTINGS) return (i == 1) ? `CSR_STATUS_UNSUPPORTED : 8'h00;
      case (i)
         2: return `CSR_STRUCT_LEN;
         4: return c;
         5: return {3'h0, k[4:0]};
         6: return d;
         default: return 8'h00; // Status zero at byte one, padding after
      endcase
   endfunction
   // Compare a whole report, leaving out what the host ignores
   task automatic report(input logic [7:0] sub, c, k, d);
      logic [7:0] m;
      for (int i = 0; i < 64; i++) begin
         m = (i == 5) ? 8'h1f : 8'hff;
         if (i != 3) chk("resp_byte", exp_byte(i, sub, c, k, d) & m, host.got[i] & m);
      end
   endtask
   // Time between two changes of the clock output
   task automatic period(input logic [7:0] div);
      logic p;
      int n;
      wr(`CSR_OFS_CLK_CFG, div);
      repeat (70) @(posedge sys_clk);
      for (int j = 0; j < 2; j++) begin
         p = clock_output;
         n = 0;
         while (clock_output === p && n < 80) begin @(posedge sys_clk); n++; end
      end
      chk("clock_period", div, 8'(n));
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h4658dd0a));
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      // Reset values, unmapped offsets read zero
      for (int a = 0; a < 8; a++) rd(3'(a), 8'h00, (a == 4) ? 8'hfc : 8'hff);
      // Random settings, all-ones corner first, sink prompt and slow
      for (int n = 0; n < 6; n++) begin
         {c, k, d} = (n == 0) ? 24'hffffff : 24'($urandom);
         wr(`CSR_OFS_CHIP_CFG, c); wr(`CSR_OFS_CLK_CFG, k); wr(`CSR_OFS_DAC_CFG, d);
         wr(`CSR_OFS_PIN_CTRL, 8'($urandom));
         rd(`CSR_OFS_CHIP_CFG, c, 8'hff); rd(`CSR_OFS_CLK_CFG, k, 8'h1f); rd(`CSR_OFS_DAC_CFG, d, 8'hff);
         host.slow = n[0];
         host.send(`CSR_CMD_READ_FLASH, `CSR_SUB_CHIP_SETTINGS, 1'b1);
         report(`CSR_SUB_CHIP_SETTINGS, c, k, d);
      end
      // Settings rewritten in mid-report do not reach it
      fork
         host.send(`CSR_CMD_READ_FLASH, `CSR_SUB_CHIP_SETTINGS, 1'b1);
         begin repeat (4) @(posedge sys_clk); wr(`CSR_OFS_CHIP_CFG, ~c); wr(`CSR_OFS_DAC_CFG, ~d); end
      join
      report(`CSR_SUB_CHIP_SETTINGS, c, k, d);
      // Unsupported sub-codes, back to back
      host.send(`CSR_CMD_READ_FLASH, 8'h07, 1'b1);
      report(8'h07, c, k, d);
      host.send(`CSR_CMD_READ_FLASH, 8'hff, 1'b1);
      report(8'hff, c, k, d);
      // Another command code gets no report
      host.send(8'h10, 8'h00, 1'b0);
      repeat (3) begin @(posedge sys_clk); chk("resp_valid", 8'h00, {7'h0, resp_valid}); end
      // Every security level code
      for (int s = 0; s < 4; s++) wr(`CSR_OFS_CHIP_CFG, 8'(s));
      // Clock output rates, then held low at divisor zero
      wr(`CSR_OFS_PIN_CTRL, 8'h08);
      period(8'h01); period(8'h02); period(8'h1f); period(8'($urandom_range(3, 30)));
      wr(`CSR_OFS_CLK_CFG, 8'h00);
      repeat (3) @(posedge sys_clk);
      chk("clock_output", 8'h00, {7'h0, clock_output});
      close_out();
   end
endmodule // tb_chip_settings_readout

// >>> verilog/csr_clkdiv.sv
// Clock output divider for the chip settings readout block.
// Assumes enable and divisor come from registers on the same clock.
`include "csr_consts.svh"

module csr_clkdiv (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Control
   input wire logic enable,
   input wire logic [4:0] divisor,
   // Divided clock
   output logic clk_out
);

   csr_pkg::csr_div_t div_reg; // Registered state
   csr_pkg::csr_div_t div_next; // Next state

   // --------------------------------------------------------------
   // Next state: toggle every divisor cycles, period 2*divisor
   // --------------------------------------------------------------
   always_comb begin
      div_next = div_reg;
      if (!enable || divisor == 5'h00) begin
         // Stopped output rests low
         div_next.count = 5'h00;
         div_next.out = 1'b0;
      end else if (div_reg.count >= divisor - 5'h01) begin
         div_next.count = 5'h00;
         div_next.out = ~div_reg.out;
      end else begin
         div_next.count = div_reg.count + 5'h01;
      end
   end

   // --------------------------------------------------------------
   // State register
   // --------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_next;
      end
   end

   assign clk_out = div_reg.out;

endmodule // csr_clkdiv

// >>> verilog/csr_readout.sv
// Chip settings readout: answers the flash-read request with the
// 64-byte chip settings report and drives the pins that the stored
// settings govern (activity indicators, clock output, DAC setup).
// Assumes busy and state inputs come from logic on sys_clk, and that
// the report sink applies back-pressure with resp_ready.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`include "csr_consts.svh"

module csr_readout (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Command report
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] cmd_sub,
   // Response report, one byte per transfer
   output logic resp_valid,
   input wire logic resp_ready,
   output logic [7:0] resp_byte,
   output logic [5:0] resp_index,
   output logic resp_last,
   // Activity and state inputs
   input wire logic uart_rx_busy,
   input wire logic uart_tx_busy,
   input wire logic i2c_busy,
   input wire logic usb_suspended,
   input wire logic usb_configured,
   // Indicator pins
   output logic rx_activity_indicator,
   output logic tx_activity_indicator,
   output logic i2c_traffic_indicator,
   output logic suspend_indicator,
   output logic usb_configured_indicator,
   // Enumeration and security
   output logic serial_number_enable,
   output logic [1:0] security_level,
   // Clock output pin
   output logic clock_output,
   // DAC setup
   output logic [1:0] dac_ref_level,
   output logic internal_voltage_reference,
   output logic [4:0] dac_value
);

   // --------------------------------------------------------------
   // State
   // --------------------------------------------------------------
   csr_pkg::csr_top_t st_reg; // Registered state
   csr_pkg::csr_top_t st_next; // Next state
   logic clk_div_out; // Divided clock from the divider
   logic resp_take; // Sink accepts the current byte
   logic cmd_take; // A command is taken this cycle

   // --------------------------------------------------------------
   // Functions
   // --------------------------------------------------------------

   // Decode the two security bits into a level
   function automatic csr_pkg::csr_sec_t sec_decode(input logic [1:0] bits);
      csr_pkg::csr_sec_t lvl;
      case (bits)
         2'h3, 2'h2: lvl = csr_pkg::CSR_SEC_LOCKED;
         2'h1: lvl = csr_pkg::CSR_SEC_PASSWORD;
         default: lvl = csr_pkg::CSR_SEC_UNSECURED;
      endcase
      return lvl;
   endfunction

   // Indicator level: idle level, inverted while its condition holds
   function automatic logic ind_level(input logic idle, input logic en, input logic active);
      return idle ^ (en & active);
   endfunction

   // Byte of the response report at a given index
   function automatic logic [7:0] report_byte(
      input logic [5:0] idx,
      input logic [7:0] status,
      input logic [7:0] chip,
      input logic [7:0] clk,
      input logic [7:0] dac
   );
      logic [7:0] b;
      b = 8'h00;
      case (idx)
         `CSR_BYTE_CMD: b = `CSR_CMD_READ_FLASH;
         `CSR_BYTE_STATUS: b = status;
         default: begin
            // Payload only follows a successful status
            if (status == `CSR_STATUS_OK) begin
               case (idx)
                  `CSR_BYTE_LEN: b = `CSR_STRUCT_LEN;
                  `CSR_BYTE_CHIP: b = chip;
                  `CSR_BYTE_CLK: b = {3'h0, clk[`CSR_CLK_DIV_HI:0]};
                  `CSR_BYTE_DAC: b = dac;
                  default: b = 8'h00;
               endcase
            end
         end
      endcase
      return b;
   endfunction

   // --------------------------------------------------------------
   // Handshakes
   // --------------------------------------------------------------
   assign cmd_ready = (st_reg.state == csr_pkg::CSR_IDLE);
   assign cmd_take = cmd_valid & cmd_ready;
   assign resp_take = st_reg.resp_valid & resp_ready;

   // --------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.rdata = 8'h00;

      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            `CSR_OFS_CHIP_CFG: st_next.chip_cfg = reg_wdata;
            `CSR_OFS_CLK_CFG: st_next.clk_cfg = reg_wdata;
            `CSR_OFS_DAC_CFG: st_next.dac_cfg = reg_wdata;
            `CSR_OFS_PIN_CTRL: st_next.pin_ctrl = reg_wdata;
            default: ; // Status and unmapped offsets ignore writes
         endcase
      end

      // Register reads, data stand for one cycle only
      if (reg_rd) begin
         case (reg_addr)
            `CSR_OFS_CHIP_CFG: st_next.rdata = st_reg.chip_cfg;
            `CSR_OFS_CLK_CFG: st_next.rdata = st_reg.clk_cfg;
            `CSR_OFS_DAC_CFG: st_next.rdata = st_reg.dac_cfg;
            `CSR_OFS_PIN_CTRL: st_next.rdata = st_reg.pin_ctrl;
            `CSR_OFS_STATUS: begin
               // Live pin levels, engine busy and lock flag
               st_next.rdata = {
                  (sec_decode(st_reg.chip_cfg[`CSR_CHIP_SEC_HI:`CSR_CHIP_SEC_LO]) == csr_pkg::CSR_SEC_LOCKED),
                  (st_reg.state == csr_pkg::CSR_SEND),
                  clk_div_out,
                  st_reg.cfg_ind,
                  st_reg.susp_ind,
                  st_reg.i2c_ind,
                  st_reg.tx_ind,
                  st_reg.rx_ind
               };
            end
            default: st_next.rdata = 8'h00; // Unmapped reads return zero
         endcase
      end

      // Response engine
      case (st_reg.state)
         csr_pkg::CSR_IDLE: begin
            if (cmd_take && cmd_code == `CSR_CMD_READ_FLASH) begin
               // Snapshot keeps the report consistent with itself
               st_next.snap_chip = st_reg.chip_cfg;
               st_next.snap_clk = st_reg.clk_cfg;
               st_next.snap_dac = st_reg.dac_cfg;
               if (cmd_sub == `CSR_SUB_CHIP_SETTINGS) begin
                  st_next.status = `CSR_STATUS_OK;
               end else begin
                  st_next.status = `CSR_STATUS_UNSUPPORTED;
               end
               st_next.index = 6'h00;
               st_next.resp_byte = `CSR_CMD_READ_FLASH;
               st_next.resp_valid = 1'b1;
               st_next.state = csr_pkg::CSR_SEND;
            end
            // Other command codes are taken and dropped
         end
         csr_pkg::CSR_SEND: begin
            if (resp_take) begin
               if (st_reg.index == `CSR_REPORT_LAST) begin
                  // Final byte accepted
                  st_next.resp_valid = 1'b0;
                  st_next.resp_byte = 8'h00;
                  st_next.index = 6'h00;
                  st_next.state = csr_pkg::CSR_IDLE;
               end else begin
                  // Present the following byte
                  st_next.index = st_reg.index + 6'h01;
                  st_next.resp_byte = report_byte(st_reg.index + 6'h01, st_reg.status,
                                                  st_reg.snap_chip, st_reg.snap_clk, st_reg.snap_dac);
               end
            end
         end
         default: begin
            st_next.state = csr_pkg::CSR_IDLE;
            st_next.resp_valid = 1'b0;
         end
      endcase

      // Indicator pins
      st_next.rx_ind = ind_level(st_reg.chip_cfg[`CSR_CHIP_RX_IDLE], 1'b1, uart_rx_busy);
      st_next.tx_ind = ind_level(st_reg.chip_cfg[`CSR_CHIP_TX_IDLE], 1'b1, uart_tx_busy);
      st_next.i2c_ind = ind_level(st_reg.chip_cfg[`CSR_CHIP_I2C_IDLE],
                                  st_reg.pin_ctrl[`CSR_PIN_I2C_EN], i2c_busy);
      st_next.susp_ind = ind_level(st_reg.chip_cfg[`CSR_CHIP_SUSP_IDLE],
                                   st_reg.pin_ctrl[`CSR_PIN_SUSP_EN], usb_suspended);
      st_next.cfg_ind = ind_level(st_reg.chip_cfg[`CSR_CHIP_CFG_IDLE],
                                  st_reg.pin_ctrl[`CSR_PIN_CFG_EN], usb_configured);
   end

   // --------------------------------------------------------------
   // State register
   // --------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st_reg <= '0;
         st_reg.state <= csr_pkg::CSR_IDLE;
         st_reg.chip_cfg <= `CSR_RST_CHIP_CFG;
         st_reg.clk_cfg <= `CSR_RST_CLK_CFG;
         st_reg.dac_cfg <= `CSR_RST_DAC_CFG;
         st_reg.pin_ctrl <= `CSR_RST_PIN_CTRL;
      end else begin
         st_reg <= st_next;
      end
   end

   // --------------------------------------------------------------
   // Clock output divider
   // --------------------------------------------------------------
   csr_clkdiv u_clkdiv (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .enable(st_reg.pin_ctrl[`CSR_PIN_CLK_EN]),
      .divisor(st_reg.clk_cfg[`CSR_CLK_DIV_HI:0]),
      .clk_out(clk_div_out)
   );

   // --------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------
   assign reg_rdata = st_reg.rdata;
   assign resp_valid = st_reg.resp_valid;
   assign resp_byte = st_reg.resp_byte;
   assign resp_index = st_reg.index;
   assign resp_last = st_reg.resp_valid & (st_reg.index == `CSR_REPORT_LAST);

   // Indicator pins
   assign rx_activity_indicator = st_reg.rx_ind;
   assign tx_activity_indicator = st_reg.tx_ind;
   assign i2c_traffic_indicator = st_reg.i2c_ind;
   assign suspend_indicator = st_reg.susp_ind;
   assign usb_configured_indicator = st_reg.cfg_ind;

   // Enumeration and security
   assign serial_number_enable = st_reg.chip_cfg[`CSR_CHIP_SERIAL_EN];
   assign security_level = sec_decode(st_reg.chip_cfg[`CSR_CHIP_SEC_HI:`CSR_CHIP_SEC_LO]);

   // Clock output
   assign clock_output = clk_div_out;

   // DAC setup
   assign dac_ref_level = st_reg.dac_cfg[`CSR_DAC_REF_HI:`CSR_DAC_REF_LO];
   assign internal_voltage_reference = st_reg.dac_cfg[`CSR_DAC_REF_SRC];
   assign dac_value = st_reg.dac_cfg[`CSR_DAC_VAL_HI:0];

endmodule // csr_readout
